// ### sci_pkg.sv
package sci_pkg;

	// clock and timing in their own units
	localparam int CLK_PERIOD_NS  = 40;       // 25 MHz system clock
	localparam int T_POWERUP_NS   = 100000;   // settle time before init
	localparam int T_RP_NS        = 20;       // row_precharge_period
	localparam int T_RCD_NS       = 20;       // activate to column command
	localparam int T_RC_NS        = 70;       // refresh_cycle_period
	localparam int T_MRD_CYC      = 2;        // mode load to next command
	localparam int T_WR_CYC       = 2;        // write recovery
	localparam int REF_PERIOD_NS  = 64000000; // refresh interval
	localparam int REF_COUNT      = 8192;     // refreshes per interval
	localparam int CAS_LAT        = 2;        // programmed read latency
	localparam int SYNC_STAGES    = 2;        // dq input synchroniser depth
	localparam int INIT_REFS      = 2;        // refreshes during init

	// least times round up, longest time rounds down
	localparam int T_POWERUP_CYC = (T_POWERUP_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int T_RP_CYC  = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RC_CYC  = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REF_INT_CYC = REF_PERIOD_NS / REF_COUNT / CLK_PERIOD_NS;
	localparam int RD_LAT    = CAS_LAT + SYNC_STAGES + 1;
	localparam int GAP_CYC   = CAS_LAT + T_WR_CYC + T_RP_CYC;

	// bus widths
	localparam int ADDR_W = 13;
	localparam int DATA_W = 16;
	localparam int COL_W  = 10;
	localparam int CNT_W  = 12;
	localparam int AP_BIT = 10; // precharge_scope_bit position

	// burst length 1, sequential, read latency 2
	localparam logic [12:0] MODE_WORD = 13'h0020;

	// command codes as {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_DESELECT_CMD  = 4'h8; // deselect_cmd
	localparam logic [3:0] CMD_NOP   = 4'h7;
	localparam logic [3:0] CMD_BST   = 4'h6; // burst_stop_cmd
	localparam logic [3:0] CMD_READ  = 4'h5;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_ACT   = 4'h3; // activate_cmd
	localparam logic [3:0] CMD_PRE   = 4'h2; // also precharge_every_cmd
	localparam logic [3:0] CMD_REF   = 4'h1;
	localparam logic [3:0] CMD_MRS   = 4'h0; // mode_load_cmd

	// controller states, one-hot
	typedef enum logic [7:0] {
		ST_POWERUP = 8'h01,
		ST_PRECHARGE_EVERY_CMD    = 8'h02,
		ST_REF     = 8'h04,
		ST_MRS     = 8'h08,
		ST_IDLE    = 8'h10,
		ST_ACT     = 8'h20,
		ST_RW      = 8'h40,
		ST_WAIT    = 8'h80
	} sci_fsm_t;

	// whole state of the controller
	typedef struct packed {
		sci_fsm_t            state;     // current step
		sci_fsm_t            ret;       // step after a wait
		logic [CNT_W-1:0]    cnt;       // wait counter
		logic [7:0]          ref_cnt;   // refresh interval timer
		logic                ref_due;   // refresh owed
		logic [1:0]          init_refs; // init refreshes left
		logic                init_done; // init finished
		logic [3:0]          cmd;       // command pins
		logic [1:0]          ba;        // bank select pins
		logic [ADDR_W-1:0]   addr;      // address pins
		logic                umask;     // upper_byte_mask pin
		logic                lmask;     // lower_byte_mask pin
		logic [DATA_W-1:0]   dq_out;    // write data
		logic                dq_oe;     // dq drive enable
		logic                cke;       // clock enable pin
		logic                req_ready; // ready for a request
		logic                r_write;   // latched request kind
		logic [1:0]          r_bank;    // latched bank
		logic [ADDR_W-1:0]   r_row;     // latched row
		logic [COL_W-1:0]    r_col;     // latched column
		logic [DATA_W-1:0]   r_wdata;   // latched write data
		logic [1:0]          r_wmask;   // latched byte masks
		logic [RD_LAT-1:0]   rd_pipe;   // read return tracker
		logic                rd_valid;  // read data strobe
		logic [DATA_W-1:0]   rd_data;   // read data
	} sci_state_t;

	localparam sci_state_t SCI_RESET = '{
		state: ST_POWERUP, ret: ST_IDLE,
		cnt: CNT_W'(T_POWERUP_CYC), ref_cnt: 8'h00, ref_due: 1'b0,
		init_refs: 2'h0, init_done: 1'b0, cmd: CMD_DESELECT_CMD, ba: 2'h0,
		addr: 13'h0000, umask: 1'b1, lmask: 1'b1, dq_out: 16'h0000,
		dq_oe: 1'b0, cke: 1'b0, req_ready: 1'b0, r_write: 1'b0,
		r_bank: 2'h0, r_row: 13'h0000, r_col: 10'h000,
		r_wdata: 16'h0000, r_wmask: 2'h0, rd_pipe: 5'h00,
		rd_valid: 1'b0, rd_data: 16'h0000};

endpackage

// ### sci_sync.sv
// two-flop synchroniser for a bus of pin inputs
module sci_sync #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	// both stages in one state word
	typedef struct packed {
		logic [W-1:0] s1; // first stage, read only by s2
		logic [W-1:0] s2; // second stage
	} sci_sync_t;

	sci_sync_t st_q; // registered state
	sci_sync_t st_d; // next state

	// shift pin value through
	always_comb begin
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end

	// register the stages
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign q = st_q.s2;

endmodule // sci_sync

// ### sci_host.sv
// Contract
// - read picks bank, column from address
// - write picks bank, column, scope bit
// - write mask sampled with data, high discards
// - wait row precharge; activate before access
// - refresh: quiet refresh period, 8192 per 64ms
// - fill idle cycles with no-op
// - mode load only with all banks idle
// - read/write encoding, scope bit autoclose
// - activate/precharge encoding, scope selects all
// - refresh/mode load encoding, bank bits low (refresh leaves bank bits as last driven)
// - byte masks independent, per lane
// - clock enable high keeps edges valid
// - no stop/access/precharge during autoclose read
module sci_host
	import sci_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              req_valid,
	input  wire logic              req_write,
	input  wire logic [1:0]        req_bank,
	input  wire logic [ADDR_W-1:0] req_row,
	input  wire logic [COL_W-1:0]  req_col,
	input  wire logic [DATA_W-1:0] req_wdata,
	input  wire logic [1:0]        req_wmask,
	output logic                   req_ready,
	output logic                   rd_valid,
	output logic      [DATA_W-1:0] rd_data,
	output logic                   init_done,
	output logic                   cke,
	output logic                   cs_n,
	output logic                   ras_n,
	output logic                   cas_n,
	output logic                   we_n,
	output logic                   bank_select_lo,
	output logic                   bank_select_hi,
	output logic      [ADDR_W-1:0] sdram_addr,
	output logic                   upper_byte_mask,
	output logic                   lower_byte_mask,
	output logic      [DATA_W-1:0] dq_out,
	output logic                   dq_oe,
	input  wire logic [DATA_W-1:0] dq_in
);

	sci_state_t        st_q;    // registered state
	sci_state_t        st_d;    // next state
	logic [DATA_W-1:0] dq_sync; // dq pins after two flops

	// read data pins cross in through two flops
	sci_sync #(
		.W(DATA_W)
	) u_dq_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.d     (dq_in),
		.q     (dq_sync)
	);

	// next-state logic for the whole controller
	always_comb begin
		st_d           = st_q;
		st_d.cmd       = CMD_NOP; // idle cycles carry no-op
		st_d.umask     = 1'b1;
		st_d.lmask     = 1'b1;
		st_d.dq_oe     = 1'b0;
		st_d.cke       = 1'b1; // keep every edge valid
		st_d.req_ready = 1'b0;
		// read return tracking
		st_d.rd_pipe   = {st_q.rd_pipe[RD_LAT-2:0], 1'b0};
		st_d.rd_valid  = st_q.rd_pipe[RD_LAT-1];
		if (st_q.rd_pipe[RD_LAT-1]) begin
			st_d.rd_data = dq_sync; // data after set latency
		end
		unique case (st_q.state)
			// wait for power to settle
			ST_POWERUP: begin
				if (st_q.cnt == CNT_W'(1)) begin
					st_d.state = ST_PRECHARGE_EVERY_CMD;
				end else begin
					st_d.cnt = st_q.cnt - CNT_W'(1);
				end
			end
			// close every bank before init refreshes
			ST_PRECHARGE_EVERY_CMD: begin
				st_d.cmd          = CMD_PRE;
				st_d.addr[AP_BIT] = 1'b1; // all banks
				st_d.init_refs    = 2'(INIT_REFS);
				st_d.state        = ST_WAIT;
				st_d.cnt          = CNT_W'(T_RP_CYC);
				st_d.ret          = ST_REF;
			end
			// auto refresh, then stay quiet
			ST_REF: begin
				st_d.cmd     = CMD_REF;
				st_d.ref_due = 1'b0;
				st_d.state   = ST_WAIT;
				st_d.cnt     = CNT_W'(T_RC_CYC);
				if (st_q.init_done) begin
					st_d.ret = ST_IDLE;
				end else begin
					st_d.init_refs = st_q.init_refs - 2'h1;
					st_d.ret = (st_q.init_refs == 2'h1) ? ST_MRS : ST_REF;
				end
			end
			// mode load while all banks are idle
			ST_MRS: begin
				st_d.cmd       = CMD_MRS;
				st_d.ba        = 2'h0;
				st_d.addr      = MODE_WORD;
				st_d.init_done = 1'b1;
				st_d.state     = ST_WAIT;
				st_d.cnt       = CNT_W'(T_MRD_CYC);
				st_d.ret       = ST_IDLE;
			end
			// a request already offered ready is honoured, then refresh
			ST_IDLE: begin
				if (req_valid && st_q.req_ready) begin
					st_d.r_write = req_write;
					st_d.r_bank  = req_bank;
					st_d.r_row   = req_row;
					st_d.r_col   = req_col;
					st_d.r_wdata = req_wdata;
					st_d.r_wmask = req_wmask;
					st_d.state   = ST_ACT;
				end else if (st_q.ref_due) begin
					st_d.state = ST_REF;
				end else begin
					st_d.req_ready = 1'b1;
				end
			end
			// open the row before any access
			ST_ACT: begin
				st_d.cmd   = CMD_ACT;
				st_d.ba    = st_q.r_bank;
				st_d.addr  = st_q.r_row;
				st_d.state = ST_WAIT;
				st_d.cnt   = CNT_W'(T_RCD_CYC);
				st_d.ret   = ST_RW;
			end
			// access with auto precharge, closed page
			ST_RW: begin
				st_d.ba   = st_q.r_bank;
				st_d.addr = {2'h0, 1'b1, st_q.r_col};
				if (st_q.r_write) begin
					st_d.cmd    = CMD_WRITE;
					st_d.dq_out = st_q.r_wdata;
					st_d.dq_oe  = 1'b1;
					st_d.umask  = st_q.r_wmask[1];
					st_d.lmask  = st_q.r_wmask[0];
				end else begin
					st_d.cmd        = CMD_READ;
					st_d.umask      = 1'b0; // lanes on two clocks on
					st_d.lmask      = 1'b0;
					st_d.rd_pipe[0] = 1'b1;
				end
				// no stop or new access until closed
				st_d.state = ST_WAIT;
				st_d.cnt   = CNT_W'(GAP_CYC);
				st_d.ret   = ST_IDLE;
			end
			// count out a timing gap
			ST_WAIT: begin
				if (st_q.cnt == CNT_W'(1)) begin
					st_d.state = st_q.ret;
				end else begin
					st_d.cnt = st_q.cnt - CNT_W'(1);
				end
			end
			// illegal code restarts the power-up wait; init_done stays set, so no mode load follows
			default: begin
				st_d.state = ST_POWERUP;
				st_d.cnt   = CNT_W'(T_POWERUP_CYC);
			end
		endcase
		// refresh timer; setting wins over the clear above
		if (st_q.ref_cnt == 8'h00) begin
			st_d.ref_cnt = 8'(REF_INT_CYC - 1);
			st_d.ref_due = 1'b1;
		end else begin
			st_d.ref_cnt = st_q.ref_cnt - 8'h01;
		end
	end

	// register the whole state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= SCI_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from flops
	assign req_ready       = st_q.req_ready;
	assign rd_valid        = st_q.rd_valid;
	assign rd_data         = st_q.rd_data;
	assign init_done       = st_q.init_done;
	assign cke             = st_q.cke;
	assign cs_n            = st_q.cmd[3];
	assign ras_n           = st_q.cmd[2];
	assign cas_n           = st_q.cmd[1];
	assign we_n            = st_q.cmd[0];
	assign bank_select_lo  = st_q.ba[0];
	assign bank_select_hi  = st_q.ba[1];
	assign sdram_addr      = st_q.addr;
	assign upper_byte_mask = st_q.umask;
	assign lower_byte_mask = st_q.lmask;
	assign dq_out          = st_q.dq_out;
	assign dq_oe           = st_q.dq_oe;

	// assertion helpers
	localparam int A_RCD = T_RCD_CYC + 1;
	logic is_rw;  // read or write on the pins
	logic is_nop; // no-op on the pins
	assign is_rw  = (st_q.cmd == CMD_READ) || (st_q.cmd == CMD_WRITE);
	assign is_nop = (st_q.cmd == CMD_NOP);

	property p_act_before_rw;
		@(posedge clk) disable iff (!rst_b)
		is_rw |-> $past(st_q.cmd == CMD_ACT, A_RCD)
			&& $past(st_q.ba, A_RCD) == st_q.ba;
	endproperty
	a_act_before_rw: assert property (p_act_before_rw)
		else $error("access without activate of that bank");

	property p_autoclose;
		@(posedge clk) disable iff (!rst_b)
		is_rw |-> st_q.addr[AP_BIT] && st_q.addr[12:11] == 2'h0;
	endproperty
	a_autoclose: assert property (p_autoclose)
		else $error("access without auto precharge");

	property p_ref_quiet;
		@(posedge clk) disable iff (!rst_b)
		(st_q.cmd == CMD_REF) |=> is_nop [*2];
	endproperty
	a_ref_quiet: assert property (p_ref_quiet)
		else $error("command inside refresh period");

	property p_pre_quiet;
		@(posedge clk) disable iff (!rst_b)
		(st_q.cmd == CMD_PRE) |=> is_nop ##1 !is_rw;
	endproperty
	a_pre_quiet: assert property (p_pre_quiet)
		else $error("command inside precharge period");

	property p_mrs_form;
		@(posedge clk) disable iff (!rst_b)
		(st_q.cmd == CMD_MRS) |-> st_q.ba == 2'h0
			&& st_q.addr == MODE_WORD && $past(st_q.cmd == CMD_NOP);
	endproperty
	a_mrs_form: assert property (p_mrs_form)
		else $error("bad mode load");

	property p_write_drive;
		@(posedge clk) disable iff (!rst_b)
		st_q.dq_oe == (st_q.cmd == CMD_WRITE);
	endproperty
	a_write_drive: assert property (p_write_drive)
		else $error("dq drive not matched to write");

	property p_read_mask;
		@(posedge clk) disable iff (!rst_b)
		(st_q.cmd == CMD_READ) |-> !st_q.umask && !st_q.lmask
			##1 st_q.umask && st_q.lmask;
	endproperty
	a_read_mask: assert property (p_read_mask)
		else $error("read masks wrong");

	property p_read_return;
		@(posedge clk) disable iff (!rst_b)
		(st_q.cmd == CMD_READ) |-> !st_q.rd_valid [*5] ##1 st_q.rd_valid;
	endproperty
	a_read_return: assert property (p_read_return)
		else $error("read data not returned on time");

	property p_no_stop;
		@(posedge clk) disable iff (!rst_b)
		st_q.cmd != CMD_BST;
	endproperty
	a_no_stop: assert property (p_no_stop)
		else $error("burst stop issued");

	property p_ref_served;
		@(posedge clk) disable iff (!rst_b)
		$rose(st_q.ref_due) && st_q.init_done
			|-> ##[1:16] (st_q.cmd == CMD_REF);
	endproperty
	a_ref_served: assert property (p_ref_served)
		else $error("refresh not served in time");

	property p_cke_high;
		@(posedge clk) disable iff (!rst_b)
		$past(rst_b) |-> st_q.cke;
	endproperty
	a_cke_high: assert property (p_cke_high)
		else $error("clock enable dropped");

endmodule // sci_host

// ### sci_sdram_model.sv
// behavioural x16 four-bank memory on the far side of the pins
module sci_sdram_model
	import sci_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              cke,
	input  wire logic              cs_n,
	input  wire logic              ras_n,
	input  wire logic              cas_n,
	input  wire logic              we_n,
	input  wire logic              bank_select_lo,
	input  wire logic              bank_select_hi,
	input  wire logic [ADDR_W-1:0] sdram_addr,
	input  wire logic              upper_byte_mask,
	input  wire logic              lower_byte_mask,
	input  wire logic [DATA_W-1:0] dq_out,
	input  wire logic              dq_oe,
	output wire logic [DATA_W-1:0] dq,
	output logic      [ADDR_W-1:0] mode_q,
	output logic      [3:0]        open_q,
	output int                     ref_cnt,
	output int                     viol
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [int];          // stored words
	logic [12:0] row_q [0:3];        // open row per bank
	logic [15:0] p_d, drv_d, last_q; // read pipe and bus history
	logic [1:0]  p_m, drv_m;         // masks riding the pipe
	logic        p_v, drv_v;
	logic [3:0]  cmd;
	logic [1:0]  bk;
	logic [15:0] old;
	int          key;
	int          quiet;              // cycles that must carry no command
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign bk = {bank_select_hi, bank_select_lo};
	// masked lanes float: show inverse of last level
	assign dq = dq_oe ? dq_out :
		{(drv_v & ~drv_m[1]) ? drv_d[15:8] : ~last_q[15:8],
		(drv_v & ~drv_m[0]) ? drv_d[7:0] : ~last_q[7:0]};
	initial begin
		open_q = 4'h0;
		quiet = 0;
		p_v = 1'b0;
		drv_v = 1'b0;
		last_q = 16'h0000;
	end
	// command decode, only on edges with clock enable high
	always @(posedge clk) begin
		last_q <= dq;
		drv_v <= p_v;
		drv_d <= p_d;
		drv_m <= p_m;
		p_v <= 1'b0;
		if (dq_oe && drv_v) viol = viol + 1;
		if (cke) begin
			key = {bk, row_q[bk], sdram_addr[9:0]};
			if (quiet > 0 && cmd[3] == 1'b0 && cmd != CMD_NOP)
				viol = viol + 1;
			if (quiet > 0) quiet = quiet - 1;
			case (cmd)
				CMD_ACT: begin
					if (open_q[bk]) viol = viol + 1;
					open_q[bk] = 1'b1;
					row_q[bk] = sdram_addr;
				end
				CMD_READ, CMD_WRITE: begin
					if (!open_q[bk]) viol = viol + 1;
					old = mem.exists(key) ? mem[key] : 16'h0000;
					if (!we_n) begin
						if (!upper_byte_mask) old[15:8] = dq[15:8];
						if (!lower_byte_mask) old[7:0] = dq[7:0];
						mem[key] = old;
					end else begin
						p_v <= 1'b1;
						p_d <= old;
						p_m <= {upper_byte_mask, lower_byte_mask};
					end
					if (sdram_addr[AP_BIT]) open_q[bk] = 1'b0;
				end
				CMD_PRE: begin
					if (sdram_addr[AP_BIT]) open_q = 4'h0;
					else open_q[bk] = 1'b0;
					quiet = T_RP_CYC;
				end
				CMD_REF: begin
					if (open_q != 4'h0) viol = viol + 1;
					ref_cnt = ref_cnt + 1;
					quiet = T_RC_CYC;
				end
				CMD_MRS: begin
					if (open_q != 4'h0 || bk != 2'h0) viol = viol + 1;
					mode_q = sdram_addr;
				end
				CMD_BST: viol = viol + 1; // never expected
				default: ;
			endcase
		end
	end
endmodule // sci_sdram_model

// ### sci_host_tb.sv
// self-checking bench: controller against the memory model
module sci_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sci_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        req_valid = 1'b0;
	logic        req_write = 1'b0;
	logic [1:0]  req_bank = 2'h0;
	logic [12:0] req_row = 13'h0000;
	logic [9:0]  req_col = 10'h000;
	logic [15:0] req_wdata = 16'h0000;
	logic [1:0]  req_wmask = 2'h0;
	logic        req_ready, rd_valid, init_done, cke, cs_n, ras_n, cas_n;
	logic        we_n, bsl, bsh, umask, lmask, dq_oe;
	logic [12:0] addr, mode_q;
	logic [15:0] rd_data, dq_out, dq;
	logic [3:0]  open_q;
	int          ref_cnt, viol, fails, tests_run, cyc;
	logic [15:0] got;
	always #20 clk = ~clk;
	sci_host dut (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
		.req_write(req_write), .req_bank(req_bank), .req_row(req_row),
		.req_col(req_col), .req_wdata(req_wdata), .req_wmask(req_wmask),
		.req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.init_done(init_done), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .bank_select_lo(bsl),
		.bank_select_hi(bsh), .sdram_addr(addr), .upper_byte_mask(umask),
		.lower_byte_mask(lmask), .dq_out(dq_out), .dq_oe(dq_oe),
		.dq_in(dq));
	sci_sdram_model mem (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .bank_select_lo(bsl),
		.bank_select_hi(bsh), .sdram_addr(addr), .upper_byte_mask(umask),
		.lower_byte_mask(lmask), .dq_out(dq_out), .dq_oe(dq_oe), .dq(dq),
		.mode_q(mode_q), .open_q(open_q), .ref_cnt(ref_cnt), .viol(viol));
	// verdict and end of run
	task stop_test;
		if (fails == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// compare and count
	task check(input string what, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			stop_test;
		end
	end
	// one request, held until the edge that takes it
	task do_req(input logic w, input logic [1:0] b, input logic [12:0] r,
		input logic [9:0] c, input logic [15:0] d, input logic [1:0] m);
		int n;
		n = 0;
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_bank <= b;
		req_row <= r;
		req_col <= c;
		req_wdata <= d;
		req_wmask <= m;
		do begin
			@(negedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 400);
		check("req_ready", n < 400, 1);
		@(posedge clk);
		req_valid <= 1'b0;
	endtask
	// read and wait for the returned word
	task rd(input logic [1:0] b, input logic [12:0] r, input logic [9:0] c);
		int n;
		n = 0;
		do_req(1'b0, b, r, c, 16'h0000, 2'h0);
		do begin
			@(negedge clk);
			n++;
		end while (rd_valid !== 1'b1 && n < 20);
		check("rd_valid", n < 20, 1);
		got = rd_data;
	endtask
	// reset pins, then init ends with the mode word loaded
	task t_reset;
		int n;
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (8) @(posedge clk);
		check("cke in reset", cke, 0);
		check("cs_n in reset", cs_n, 1);
		check("dq_oe in reset", dq_oe, 0);
		rst_b <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (init_done !== 1'b1 && n < 3000);
		check("init_done", init_done, 1);
		// the memory takes the mode load one edge after the pins show it
		@(negedge clk);
		check("mode word", mode_q, MODE_WORD);
	endtask
	// every bank, edge rows and columns, interleaved
	task t_banks;
		for (int b = 0; b < 4; b++)
			do_req(1'b1, 2'(b), 13'(8191 - b), 10'(1023 * (b % 2)),
				16'(16'h1111 * b + 16'h0F0F), 2'h0);
		for (int b = 0; b < 4; b++) begin
			rd(2'(b), 13'(8191 - b), 10'(1023 * (b % 2)));
			check("bank data", got, 16'(16'h1111 * b + 16'h0F0F));
			check("row closed", open_q, 0);
		end
	endtask
	// byte masks on writes, each lane on its own
	task t_mask;
		do_req(1'b1, 2'h2, 13'h0055, 10'h155, 16'hA5C3, 2'h0);
		do_req(1'b1, 2'h2, 13'h0055, 10'h155, 16'h1234, 2'h2);
		rd(2'h2, 13'h0055, 10'h155);
		check("upper masked", got, 16'hA534);
		do_req(1'b1, 2'h2, 13'h0055, 10'h155, 16'hFFFF, 2'h1);
		do_req(1'b1, 2'h2, 13'h0055, 10'h155, 16'h0000, 2'h3);
		rd(2'h2, 13'h0055, 10'h155);
		check("lower masked", got, 16'hFF34);
	endtask
	// idle stretch: refreshes keep coming, pins never deselect
	task t_idle;
		int r0, deselect_cmd;
		r0 = ref_cnt;
		deselect_cmd = 0;
		repeat (600) begin
			@(negedge clk);
			if (cs_n !== 1'b0) deselect_cmd++;
		end
		check("refreshes", ref_cnt - r0 >= 600 / REF_INT_CYC, 1);
		check("deselects", deselect_cmd, 0);
	endtask
	initial begin
		t_reset;
		t_banks;
		t_mask;
		t_idle;
		t_reset;
		rd(2'h2, 13'h0055, 10'h155);
		check("after reset", got, 16'hFF34);
		check("pin protocol", viol, 0);
		stop_test;
	end
endmodule // sci_host_tb
